/* src/acs_consts.svh */
// constants of the accumulator shifter: offsets, field positions, limits, reset values
//
// Summary of operation
// - logical shift by count register clamps count to -32..+31, no overflow raised
// - logical accumulator shift puts last bit out in carry; zero count clears carry
// - logical accumulator shifts run on a 40-bit datapath steered by forty-bit mode
// - forty-bit mode off: logical shift result has guard bits 39..32 cleared
// - negative count shifts right by its magnitude, positive count shifts left
// - legacy mode logical count uses 6 low bits; -32..-17 fold modulo 16 to -16..-1
// - one-bit logical shift: accumulator dest uses shifter, aux/temp dest uses address ALU
// - signed shift by count register clamps to -32..+31 and flags overflow on clamping
// - forty-bit off, sign extension off: signed shifter input guard bits are zeros
// - forty-bit off, sign extension on: signed shifter input guard bits copy bit 31
// - signed shift sign position is bit 31, or bit 39 when forty-bit mode on
// - every unsaturated signed left shift fills result bit 0 with zero
// - forty-bit off: signed overflow detected at bit 31 sets destination overflow flag
// - forty-bit on: signed overflow detected at bit 39 sets destination overflow flag
// - saturation on, forty-bit off, overflow: load 00_7fff_ffff or ff_8000_0000
// - saturation on, forty-bit on, overflow: load 7f_ffff_ffff or 80_0000_0000
// - legacy mode signed shifts act forty-bit, with no overflow flag or saturation
// - legacy mode signed count uses 6 low bits; -32..-17 fold modulo 16 to -16..-1
// - signed shifted-out bit follows forty-bit mode; only carry variants write carry (status carry bit still loads on every shift)
// - signed shifts take count from temporary register or from instruction immediate
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define ACS_ADDR_MODE 8'h00
`define ACS_ADDR_STATUS 8'h04

`define ACS_MODE_FORTY_BIT 0
`define ACS_MODE_SIGN_EXT 1
`define ACS_MODE_DATA_SAT 2
`define ACS_MODE_LEGACY 3
`define ACS_MODE_RESET 4'ha

`define ACS_STAT_CARRY 0
`define ACS_STAT_OVF 1
`define ACS_STAT_CLAMP 2
`define ACS_STAT_SAT 3

// ****************************************************************
// shift count limits
// ****************************************************************
`define ACS_CNT_MAX 16'h001f
`define ACS_CNT_MIN 16'hffe0
`define ACS_AMT_MAX 7'h1f
`define ACS_AMT_MIN 7'h60
`define ACS_AMT_ONE 7'h01
`define ACS_AMT_MINUS_ONE 7'h7f
`define ACS_LEGACY_MOD 7'h10

// ****************************************************************
// saturation values
// ****************************************************************
`define ACS_SAT_POS_32 40'h007fffffff
`define ACS_SAT_NEG_32 40'hff80000000
`define ACS_SAT_POS_40 40'h7fffffffff
`define ACS_SAT_NEG_40 40'h8000000000

`endif

/* src/acs_pkg.sv */
// types shared by the accumulator shifter files
package acs_pkg;

  typedef enum logic [2:0] {
    op_lsh_cnt,
    op_lsh_imm,
    op_lsh1_left,
    op_lsh1_right,
    op_ssh_cnt,
    op_ssh_cnt_c,
    op_ssh_imm,
    op_ssh_imm_c
  } acs_op_t;

  typedef struct packed {
    logic valid;
    acs_op_t op;
    logic dest_is_acc;
    logic [39:0] source_accumulator;
    logic [15:0] count;
    logic [5:0] immediate_shift_value;
    logic [15:0] aux_or_temp_register;
  } acs_req_t;

  typedef struct packed {
    logic valid;
    logic [39:0] result;
    logic dest_is_acc;
    logic carry_we;
    logic carry;
    logic dest_acc_overflow_flag;
    logic saturated;
  } acs_res_t;

endpackage

/* src/acs_count_norm.sv */
// shift count selection, clamping and legacy folding
`timescale 1ns/1ns
`include "acs_consts.svh"
module acs_count_norm (
  input wire logic [15:0] count,
  input wire logic use_count_reg,
  input wire logic [5:0] immediate_shift_value,
  input wire logic legacy_compat_mode,
  output logic [6:0] amount,
  output logic clamped
);

  always_comb begin
    amount = {immediate_shift_value[5], immediate_shift_value};
    clamped = 1'b0;
    if (use_count_reg) begin
      if (legacy_compat_mode) begin
        // 6-bit values -32..-17 sit at 6'h20..6'h2f
        if (count[5:4] == 2'b10) begin
          amount = {1'b1, count[5:0]} + `ACS_LEGACY_MOD;
        end else begin
          amount = {count[5], count[5:0]};
        end
      end else if ($signed(count) > $signed(`ACS_CNT_MAX)) begin
        amount = `ACS_AMT_MAX;
        clamped = 1'b1;
      end else if ($signed(count) < $signed(`ACS_CNT_MIN)) begin
        amount = `ACS_AMT_MIN;
        clamped = 1'b1;
      end else begin
        amount = count[6:0];
      end
    end
  end

endmodule

/* src/acs_shifter.sv */
// forty-bit accumulator shifter with mode register and status register
`timescale 1ns/1ns
`include "acs_consts.svh"
module acs_shifter (
  input wire logic sys_clk,
  input wire logic srst,
  input wire acs_pkg::acs_req_t req,
  output acs_pkg::acs_res_t res,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata
);
  import acs_pkg::*;

  // ****************************************************************
  // mode and status registers
  // ****************************************************************
  logic [3:0] mode;
  logic [3:0] status;
  logic forty_bit_mode;
  logic sign_extension_mode;
  logic data_saturation_mode;
  logic legacy_compat_mode;

  assign forty_bit_mode = mode[`ACS_MODE_FORTY_BIT];
  assign sign_extension_mode = mode[`ACS_MODE_SIGN_EXT];
  assign data_saturation_mode = mode[`ACS_MODE_DATA_SAT];
  assign legacy_compat_mode = mode[`ACS_MODE_LEGACY];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode <= `ACS_MODE_RESET;
    end else if (reg_we && reg_addr == `ACS_ADDR_MODE) begin
      mode <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_re) begin
      if (reg_addr == `ACS_ADDR_MODE) begin
        reg_rdata <= {28'h0000000, mode};
      end else if (reg_addr == `ACS_ADDR_STATUS) begin
        reg_rdata <= {28'h0000000, status};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ****************************************************************
  // operation decode
  // ****************************************************************
  logic is_lsh;
  logic is_one_bit;
  logic use_count_reg;
  logic carry_variant;
  logic aux_path;

  assign is_one_bit = (req.op == op_lsh1_left) || (req.op == op_lsh1_right);
  assign is_lsh = (req.op == op_lsh_cnt) || (req.op == op_lsh_imm) || is_one_bit;
  assign use_count_reg = (req.op == op_lsh_cnt) || (req.op == op_ssh_cnt) ||
                         (req.op == op_ssh_cnt_c);
  assign carry_variant = is_lsh || (req.op == op_ssh_cnt_c) || (req.op == op_ssh_imm_c);
  // one-bit shifts into aux/temp registers bypass the wide shifter
  assign aux_path = is_one_bit && !req.dest_is_acc;

  // ****************************************************************
  // shift amount
  // ****************************************************************
  logic [6:0] norm_amount;
  logic clamped;
  logic [6:0] amount;
  logic shift_right;
  logic [6:0] mag;
  logic zero_count;

  acs_count_norm u_count_norm (
    .count(req.count),
    .use_count_reg(use_count_reg),
    .immediate_shift_value(req.immediate_shift_value),
    .legacy_compat_mode(legacy_compat_mode),
    .amount(norm_amount),
    .clamped(clamped)
  );

  always_comb begin
    if (req.op == op_lsh1_left) begin
      amount = `ACS_AMT_ONE;
    end else if (req.op == op_lsh1_right) begin
      amount = `ACS_AMT_MINUS_ONE;
    end else begin
      amount = norm_amount;
    end
  end

  assign shift_right = amount[6];
  assign mag = amount[6] ? (~amount + `ACS_AMT_ONE) : amount;
  assign zero_count = (amount == 7'h00);

  // ****************************************************************
  // logical path
  // ****************************************************************
  logic [39:0] lsh_in;
  logic [79:0] lsh_left;
  logic [79:0] lsh_right;
  logic [39:0] lsh_val;
  logic lsh_carry;

  // without forty-bit mode only the low word takes part
  assign lsh_in = forty_bit_mode ? req.source_accumulator :
                  {8'h00, req.source_accumulator[31:0]};
  assign lsh_left = {40'h0000000000, lsh_in} << mag;
  assign lsh_right = {lsh_in, 40'h0000000000} >> mag;

  always_comb begin
    if (shift_right) begin
      lsh_val = lsh_right[79:40];
      lsh_carry = lsh_right[39];
    end else begin
      lsh_val = lsh_left[39:0];
      lsh_carry = forty_bit_mode ? lsh_left[40] : lsh_left[32];
    end
    if (!forty_bit_mode) begin
      lsh_val[39:32] = 8'h00;
    end
  end

  // ****************************************************************
  // address-unit one-bit path
  // ****************************************************************
  logic [15:0] aux_val;
  logic aux_carry;

  always_comb begin
    if (req.op == op_lsh1_left) begin
      aux_val = {req.aux_or_temp_register[14:0], 1'b0};
      aux_carry = req.aux_or_temp_register[15];
    end else begin
      aux_val = {1'b0, req.aux_or_temp_register[15:1]};
      aux_carry = req.aux_or_temp_register[0];
    end
  end

  // ****************************************************************
  // signed path
  // ****************************************************************
  logic m40_eff;
  logic [7:0] guard_in;
  logic [39:0] ssh_in;
  logic [79:0] ssh_left;
  logic [79:0] ssh_right;
  logic [39:0] ssh_val;
  logic ssh_carry;
  logic ssh_ovf;
  logic ssh_neg;
  logic [39:0] sat_val;
  logic do_sat;

  // legacy mode behaves as if forty-bit mode were set
  assign m40_eff = forty_bit_mode || legacy_compat_mode;
  assign guard_in = sign_extension_mode ? {8{req.source_accumulator[31]}} : 8'h00;
  assign ssh_in = m40_eff ? req.source_accumulator :
                  {guard_in, req.source_accumulator[31:0]};
  // left shift fills from zero at bit 0
  assign ssh_left = {{40{ssh_in[39]}}, ssh_in} << mag;
  assign ssh_right = $signed({ssh_in, 40'h0000000000}) >>> mag;

  always_comb begin
    if (shift_right) begin
      ssh_val = ssh_right[79:40];
      ssh_carry = ssh_right[39];
      ssh_neg = ssh_in[39];
      // arithmetic right shift cannot leave the 40-bit range
      ssh_ovf = !m40_eff && !((&ssh_val[39:31]) || !(|ssh_val[39:31]));
    end else begin
      ssh_val = ssh_left[39:0];
      ssh_carry = m40_eff ? ssh_left[40] : ssh_left[32];
      ssh_neg = ssh_left[79];
      if (m40_eff) begin
        ssh_ovf = !((&ssh_left[79:39]) || !(|ssh_left[79:39]));
      end else begin
        ssh_ovf = !((&ssh_left[79:31]) || !(|ssh_left[79:31]));
      end
    end
  end

  always_comb begin
    if (m40_eff) begin
      sat_val = ssh_neg ? `ACS_SAT_NEG_40 : `ACS_SAT_POS_40;
    end else begin
      sat_val = ssh_neg ? `ACS_SAT_NEG_32 : `ACS_SAT_POS_32;
    end
  end

  assign do_sat = data_saturation_mode && ssh_ovf && !legacy_compat_mode;

  // ****************************************************************
  // result register, one cycle after the request
  // ****************************************************************
  acs_res_t next_res;

  always_comb begin
    next_res = '0;
    if (req.valid) begin
      next_res.valid = 1'b1;
      next_res.dest_is_acc = !aux_path;
      if (aux_path) begin
        next_res.result = {24'h000000, aux_val};
        next_res.carry_we = 1'b1;
        next_res.carry = aux_carry;
      end else if (is_lsh) begin
        next_res.result = lsh_val;
        next_res.carry_we = 1'b1;
        next_res.carry = zero_count ? 1'b0 : lsh_carry;
      end else begin
        next_res.result = do_sat ? sat_val : ssh_val;
        next_res.saturated = do_sat;
        next_res.carry_we = carry_variant;
        next_res.carry = zero_count ? 1'b0 : ssh_carry;
        // clamp report only for the register count
        next_res.dest_acc_overflow_flag = !legacy_compat_mode &&
                                          (ssh_ovf || clamped);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      res <= '0;
    end else begin
      res <= next_res;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status <= 4'h0;
    end else if (req.valid) begin
      status[`ACS_STAT_CARRY] <= next_res.carry;
      status[`ACS_STAT_OVF] <= next_res.dest_acc_overflow_flag;
      status[`ACS_STAT_CLAMP] <= clamped;
      status[`ACS_STAT_SAT] <= next_res.saturated;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_LATENCY: assert property (
    @(posedge sys_clk) disable iff (srst)
    req.valid |=> res.valid ##1 (res.valid == $past(req.valid))
  ) else $error("result valid does not follow request by one cycle");

  AST_LSH_NO_OVF: assert property (
    @(posedge sys_clk) disable iff (srst)
    (req.valid && is_lsh) |=> (!res.dest_acc_overflow_flag && res.carry_we)
  ) else $error("logical shift raised overflow or skipped carry");

  AST_LSH_ZERO_CARRY: assert property (
    @(posedge sys_clk) disable iff (srst)
    (req.valid && carry_variant && !aux_path && req.op != op_lsh1_left &&
     req.op != op_lsh1_right && req.count == 16'h0000 && use_count_reg)
    |=> (res.carry == 1'b0)
  ) else $error("zero shift count did not clear carry");

  AST_LSH_GUARD: assert property (
    @(posedge sys_clk) disable iff (srst)
    (req.valid && is_lsh && !aux_path && !forty_bit_mode) |=> (res.result[39:32] == 8'h00)
  ) else $error("logical shift left guard bits set with forty-bit mode off");

  AST_LSH_DIR: assert property (
    @(posedge sys_clk) disable iff (srst)
    (req.valid && req.op == op_lsh_imm && forty_bit_mode &&
     req.immediate_shift_value == 6'h3f)
    |=> (res.result == {1'b0, $past(req.source_accumulator[39:1])})
  ) else $error("count of -1 did not shift right by one");

  AST_AUX_PATH: assert property (
    @(posedge sys_clk) disable iff (srst)
    (req.valid && req.op == op_lsh1_left && !req.dest_is_acc)
    |=> (!res.dest_is_acc && res.result[15:0] == {$past(req.aux_or_temp_register[14:0]), 1'b0}
         && res.carry == $past(req.aux_or_temp_register[15]))
  ) else $error("one-bit shift to aux register took the wrong path");

  AST_SSH_CLAMP_OVF: assert property (
    @(posedge sys_clk) disable iff (srst)
    (req.valid && req.op == op_ssh_cnt && !legacy_compat_mode &&
     ($signed(req.count) > $signed(`ACS_CNT_MAX) || $signed(req.count) < $signed(`ACS_CNT_MIN)))
    |=> res.dest_acc_overflow_flag
  ) else $error("clamped signed count did not flag overflow");

  AST_SSH_GUARD_ZERO: assert property (
    @(posedge sys_clk) disable iff (srst)
    (req.valid && !is_lsh && !m40_eff && !sign_extension_mode && !data_saturation_mode &&
     req.op == op_ssh_imm && req.immediate_shift_value == 6'h00)
    |=> (res.result == {8'h00, $past(req.source_accumulator[31:0])})
  ) else $error("guard bits not cleared at signed shifter input");

  AST_SSH_BIT0: assert property (
    @(posedge sys_clk) disable iff (srst)
    (req.valid && !is_lsh && !amount[6] && amount != 7'h00 && !do_sat) |=> !res.result[0]
  ) else $error("signed left shift did not fill bit 0 with zero");

  AST_SAT_32: assert property (
    @(posedge sys_clk) disable iff (srst)
    (req.valid && !is_lsh && do_sat && !m40_eff)
    |=> (res.saturated && (res.result == `ACS_SAT_POS_32 || res.result == `ACS_SAT_NEG_32))
  ) else $error("wrong saturation value with forty-bit mode off");

  AST_SAT_40: assert property (
    @(posedge sys_clk) disable iff (srst)
    (req.valid && !is_lsh && do_sat && m40_eff)
    |=> (res.saturated && (res.result == `ACS_SAT_POS_40 || res.result == `ACS_SAT_NEG_40))
  ) else $error("wrong saturation value with forty-bit mode on");

  AST_LEGACY_QUIET: assert property (
    @(posedge sys_clk) disable iff (srst)
    (req.valid && !is_lsh && legacy_compat_mode)
    |=> (!res.dest_acc_overflow_flag && !res.saturated)
  ) else $error("legacy mode signed shift flagged overflow or saturated");

  AST_CARRY_VARIANT: assert property (
    @(posedge sys_clk) disable iff (srst)
    (req.valid && (req.op == op_ssh_cnt || req.op == op_ssh_imm)) |=> !res.carry_we
  ) else $error("non-carry signed shift wrote carry");

endmodule

/* verification/acs_cpu_model.sv */
// behavioural model of the instruction pipeline that feeds the shifter
`timescale 1ns/1ns
module acs_cpu_model (
  input wire logic sys_clk,
  input wire logic srst,
  output acs_pkg::acs_req_t req
);
  import acs_pkg::*;

  // ****************************************************************
  // request issue
  // ****************************************************************
  initial begin
    req = '0;
  end

  // operands go to their inverse once released, so stale fields never look valid
  task automatic issue(input acs_req_t r);
    acs_req_t idle;
    @(posedge sys_clk);
    r.valid = ~srst;
    req <= r;
    idle = acs_req_t'(~r);
    idle.valid = 1'b0;
    @(posedge sys_clk);
    req <= idle;
  endtask
endmodule

/* verification/tb.sv */
// self-checking testbench of the accumulator shifter
`timescale 1ns/1ns
module tb;
  import acs_pkg::*;
  logic sys_clk;
  logic srst;
  acs_req_t req;
  acs_res_t res;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [31:0] reg_rdata;
  acs_req_t r;
  int n_mismatch;
  int comparisons;
  int cycles;

  acs_shifter i_acs_shifter (.sys_clk(sys_clk), .srst(srst), .req(req), .res(res),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata));
  acs_cpu_model i_acs_cpu_model (.sys_clk(sys_clk), .srst(srst), .req(req));

  // ****************************************************************
  // clock, timeout, reporting
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // whole run is about a hundred cycles; anything far beyond is a hang
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1;
    check({32'h0, reg_rdata}, {32'h0, exp});
  endtask

  function automatic acs_req_t mk(input acs_op_t op, input logic [39:0] src,
    input logic [15:0] cnt, input logic [5:0] imm);
    acs_req_t q;
    q = '0;
    q.valid = 1'b1;
    q.op = op;
    q.dest_is_acc = 1'b1;
    q.source_accumulator = src;
    q.count = cnt;
    q.immediate_shift_value = imm;
    return q;
  endfunction

  // ef is carry write, carry, overflow flag, saturated
  task automatic sh(input acs_req_t q, input logic [39:0] er, input logic [3:0] ef);
    i_acs_cpu_model.issue(q);
    #1;
    check({18'h0, res.valid, res.dest_is_acc, res.result, res.carry_we, res.carry,
      res.dest_acc_overflow_flag, res.saturated}, {18'h0, 1'b1, q.dest_is_acc, er, ef});
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    cycles = 0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    reg_read(8'h00, 32'ha);
    reg_read(8'h04, 32'h0);
    reg_write(8'h04, 32'hf);
    reg_read(8'h04, 32'h0);
    reg_read(8'h10, 32'h0);
    // forty-bit off, legacy off
    reg_write(8'h00, 32'h0);
    sh(mk(op_lsh_cnt, 40'h5fb0001234, 16'hfffa, 6'h00), 40'h0002c00048, 4'b1100);
    sh(mk(op_lsh_imm, 40'hff12345678, 16'h0000, 6'h00), 40'h0012345678, 4'b1000);
    sh(mk(op_lsh_imm, 40'h0010000000, 16'h0000, 6'h04), 40'h0000000000, 4'b1100);
    sh(mk(op_ssh_imm, 40'hff80000000, 16'h0000, 6'h3f), 40'h0040000000, 4'b0000);
    sh(mk(op_ssh_imm, 40'h0040000000, 16'h0000, 6'h01), 40'h0080000000, 4'b0010);
    sh(mk(op_ssh_imm, 40'hff12345678, 16'h0000, 6'h00), 40'h0012345678, 4'b0000);
    // forty-bit on
    reg_write(8'h00, 32'h1);
    sh(mk(op_lsh_imm, 40'h0f00000000, 16'h0000, 6'h04), 40'hf000000000, 4'b1000);
    sh(mk(op_lsh_cnt, 40'h0000000001, 16'h0100, 6'h00), 40'h0080000000, 4'b1000);
    reg_read(8'h04, 32'h4);
    sh(mk(op_lsh_cnt, 40'hff80000000, 16'h8000, 6'h00), 40'h00000000ff, 4'b1100);
    r = mk(op_lsh1_left, 40'h0, 16'h0000, 6'h00);
    r.dest_is_acc = 1'b0;
    r.aux_or_temp_register = 16'h8001;
    sh(r, 40'h0000000002, 4'b1100);
    r.op = op_lsh1_right;
    sh(r, 40'h0000004000, 4'b1100);
    sh(mk(op_lsh_imm, 40'h8000000003, 16'h0000, 6'h3f), 40'h4000000001, 4'b1100);
    sh(mk(op_lsh1_right, 40'h8000000003, 16'h0000, 6'h00), 40'h4000000001, 4'b1100);
    sh(mk(op_ssh_cnt, 40'h0, 16'h7fff, 6'h00), 40'h0, 4'b0010);
    sh(mk(op_ssh_imm, 40'h0040000000, 16'h0000, 6'h01), 40'h0080000000, 4'b0000);
    // carry value is shown but not written: carry_we stays low for plain signed shifts
    sh(mk(op_ssh_imm, 40'hffffffffff, 16'h0000, 6'h01), 40'hfffffffffe, 4'b0100);
    sh(mk(op_ssh_cnt_c, 40'h0000000005, 16'h0000, 6'h00), 40'h0000000005, 4'b1000);
    sh(mk(op_ssh_imm_c, 40'h0000000005, 16'h0000, 6'h00), 40'h0000000005, 4'b1000);
    // saturation and sign extension, forty-bit off
    reg_write(8'h00, 32'h4);
    sh(mk(op_ssh_imm, 40'hff40000000, 16'h0000, 6'h01), 40'h007fffffff, 4'b0011);
    reg_write(8'h00, 32'h6);
    sh(mk(op_ssh_imm_c, 40'h0080000001, 16'h0000, 6'h01), 40'hff80000000, 4'b1111);
    reg_write(8'h00, 32'h2);
    sh(mk(op_ssh_imm, 40'h0080000000, 16'h0000, 6'h3f), 40'hffc0000000, 4'b0000);
    // saturation, forty-bit on
    reg_write(8'h00, 32'h5);
    sh(mk(op_ssh_cnt_c, 40'h4000000000, 16'h0001, 6'h00), 40'h7fffffffff, 4'b1011);
    reg_read(8'h04, 32'ha);
    sh(mk(op_ssh_imm, 40'h8000000000, 16'h0000, 6'h01), 40'h8000000000, 4'b0111);
    // legacy mode
    reg_write(8'h00, 32'hc);
    sh(mk(op_ssh_cnt_c, 40'h4000000000, 16'h0001, 6'h00), 40'h8000000000, 4'b1000);
    reg_write(8'h00, 32'h8);
    reg_read(8'h00, 32'h8);
    sh(mk(op_ssh_cnt, 40'h1234560000, 16'h00e0, 6'h00), 40'h0000123456, 4'b0000);
    sh(mk(op_lsh_cnt, 40'h0012345678, 16'h0fe0, 6'h00), 40'h0000001234, 4'b1000);
    repeat (2) @(posedge sys_clk);
    give_verdict();
  end
endmodule
